// ===== design/bt_pkg.sv
// Shared constants and types for the basic timer
package bt_pkg;

  // Data path widths
  localparam int unsigned BT_COUNT_W = 16;
  localparam int unsigned BT_MODE_W = 2;
  localparam int unsigned BT_FILTER_W = 3;
  localparam int unsigned BT_CASCADE_SEL_W = 3;
  localparam int unsigned BT_CASCADE_SRC_N = 8;
  localparam int unsigned BT_FLAG_W = 2;

  // Bit positions in the flag-clear word
  localparam int unsigned BT_FLAG_WRAP_BIT = 0;
  localparam int unsigned BT_FLAG_TRIG_BIT = 1;

  // Values after reset
  localparam logic [15:0] BT_COUNT_RESET = 16'h0000;
  localparam logic [15:0] BT_PRESCALE_RESET = 16'h0000;
  localparam logic [2:0] BT_FILTER_CNT_RESET = 3'h0;

  // Cascade selector code that a timer must not pick for itself
  localparam logic [2:0] BT_SELF_CODE_DEFAULT = 3'h0;

  // Operating modes
  typedef enum logic [1:0] {
    BT_MODE_TIMER,
    BT_MODE_COUNTER,
    BT_MODE_TRIGGER,
    BT_MODE_GATED
  } bt_mode_t;

endpackage

// ===== design/bt_input_filter.sv
`timescale 1ns/10ps
// Majority-free glitch filter: output follows the input only after the
// input has differed from it for a run of consecutive samples
module bt_input_filter (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Synchronised pin level and filter depth, zero bypasses the filter
  input wire logic i_level,
  input wire logic [2:0] i_setting,
  // Filtered level
  output logic o_level
);

  typedef struct packed {
    logic [2:0] run;
    logic level;
  } bt_filt_state_t;

  bt_filt_state_t state_reg;
  bt_filt_state_t state_next;

  // Count consecutive mismatching samples and switch when the run is long enough
  always_comb begin
    state_next = state_reg;
    if (i_setting == bt_pkg::BT_FILTER_CNT_RESET) begin
      state_next.level = i_level;
      state_next.run = bt_pkg::BT_FILTER_CNT_RESET;
    end else if (i_level != state_reg.level) begin
      if (state_reg.run + 3'h1 >= i_setting) begin
        state_next.level = i_level;
        state_next.run = bt_pkg::BT_FILTER_CNT_RESET;
      end else begin
        state_next.run = state_reg.run + 3'h1;
      end
    end else begin
      state_next.run = bt_pkg::BT_FILTER_CNT_RESET;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.level;

endmodule

// ===== design/bt_cascade_select.sv
`timescale 1ns/10ps
// Picks one cascade pulse out of the eight on-chip sources
module bt_cascade_select #(
  parameter logic [2:0] SELF_CODE = bt_pkg::BT_SELF_CODE_DEFAULT
) (
  // Overflow pulses: 0-2 basic timers, 3-6 general timers, 7 advanced master
  input wire logic [7:0] i_sources,
  // Selector code
  input wire logic [2:0] i_select,
  // Selected pulse
  output logic o_pulse
);

  // Own overflow is blocked so a misconfigured timer cannot feed itself
  always_comb begin
    if (i_select == SELF_CODE) begin
      o_pulse = 1'b0;
    end else begin
      o_pulse = i_sources[i_select];
    end
  end

endmodule

// ===== design/bt_basic_timer.sv
// Contract
// - Two-bit mode: 00 timer, 01 counter, 10 trigger-start, 11 gated.
// - Timer mode counts prescaled bus clock while enable is set.
// - Count reaching reload gives overflow pulse and sets wrap flag.
// - Interrupt requested when wrap flag and its enable are both set.
// - Writing 0 to wrap bit of flag clear clears it; software must.
// - Timer period equals (prescale+1) times (reload+1) bus clocks.
// - Counter mode counts cascade input if source select 1, else pin.
// - Pin source is filtered and counted on edge chosen by active sense.
// - Trigger mode starts on enable write of 1 or a valid trigger.
// - Trigger comes from cascade input if source select 1, else pin edge.
// - Valid trigger sets enable, sets trigger flag, counts from held value.
// - Trigger mode: clearing enable halts at once; resume from held value.
// - Gated mode counts prescaled clock only with enable and active gate.
// - Gate is always the filtered pin, level chosen by active sense.
// - Gated mode stops at once when enable or gate drops; then resumes.
// - Overflow output feeds downstream timers to build wider counts.
// - First stage counts clock or pin; later stages count cascade pulses.
// - Three-bit cascade selector picks among eight timer sources.
// - All basic timers share one external count pin signal.
// - Active sense 0 means high or rising; 1 means low or falling.
// - Divide by prescale+1 on bus clock, by prescale on event sources.
// - Single run stops and clears enable on overflow; continuous wraps.
`timescale 1ns/10ps
module bt_basic_timer #(
  parameter logic [2:0] SELF_CODE = bt_pkg::BT_SELF_CODE_DEFAULT
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Configuration
  input wire logic [1:0] i_mode,
  input wire logic i_single_run_select,
  input wire logic i_source_select,
  input wire logic i_active_sense,
  input wire logic [2:0] i_input_filter_setting,
  input wire logic [15:0] i_prescale_value,
  input wire logic [15:0] i_reload_value,
  input wire logic [2:0] i_cascade_source_select,
  // Software write strobes
  input wire logic i_enable_wr,
  input wire logic i_enable_wdata,
  input wire logic i_count_wr,
  input wire logic [15:0] i_count_wdata,
  input wire logic i_flag_clear_wr,
  input wire logic [1:0] i_flag_clear_wdata,
  // Interrupt enables
  input wire logic i_irq_enable_wrap,
  input wire logic i_irq_enable_trigger,
  // Cascade pulses and the shared pin
  input wire logic [7:0] i_cascade_sources,
  input wire logic i_external_count_pin,
  // Status and events
  output logic o_enable,
  output logic [15:0] o_count_value,
  output logic o_wrap_flag,
  output logic o_trigger_flag,
  output logic o_overflow,
  output logic o_irq
);

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic filt_prev;
    logic enable;
    logic wrap_flag;
    logic trigger_flag;
    logic overflow;
    logic [15:0] count_value;
    logic [15:0] presc_cnt;
    logic [15:0] presc_active;
  } bt_state_t;

  bt_state_t state_reg;
  bt_state_t state_next;

  bt_pkg::bt_mode_t mode;
  logic filt_level;
  logic cascade_pulse;
  logic pin_edge;
  logic gate_active;
  logic trigger_event;
  logic clock_source;
  logic advance;
  logic [15:0] div_last;
  logic tick;
  logic wrap_hit;

  assign mode = bt_pkg::bt_mode_t'(i_mode);

  // Filter on the synchronised copy of the shared pin
  bt_input_filter u_filter (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_level(state_reg.pin_sync),
    .i_setting(i_input_filter_setting),
    .o_level(filt_level)
  );

  // Cascade source multiplexer
  bt_cascade_select #(
    .SELF_CODE(SELF_CODE)
  ) u_cascade (
    .i_sources(i_cascade_sources),
    .i_select(i_cascade_source_select),
    .o_pulse(cascade_pulse)
  );

  // Pin edge, gate level and trigger detection
  always_comb begin
    pin_edge = i_active_sense ? (state_reg.filt_prev & ~filt_level)
                              : (~state_reg.filt_prev & filt_level);
    gate_active = filt_level ^ i_active_sense;
    trigger_event = (mode == bt_pkg::BT_MODE_TRIGGER) &&
                    (i_source_select ? cascade_pulse : pin_edge);
  end

  // Which mode lets the prescaler step this cycle
  always_comb begin
    clock_source = 1'b1;
    advance = 1'b0;
    case (mode)
      bt_pkg::BT_MODE_TIMER: begin
        advance = state_reg.enable;
      end
      bt_pkg::BT_MODE_COUNTER: begin
        clock_source = 1'b0;
        advance = state_reg.enable &&
                  (i_source_select ? cascade_pulse : pin_edge);
      end
      bt_pkg::BT_MODE_TRIGGER: begin
        advance = state_reg.enable;
      end
      bt_pkg::BT_MODE_GATED: begin
        advance = state_reg.enable && gate_active;
      end
      default: begin
        advance = 1'b0;
      end
    endcase
  end

  // Prescaler terminal value and counter step
  always_comb begin
    if (clock_source) begin
      div_last = state_reg.presc_active;
    end else if (state_reg.presc_active == bt_pkg::BT_PRESCALE_RESET) begin
      div_last = bt_pkg::BT_PRESCALE_RESET;
    end else begin
      div_last = state_reg.presc_active - 16'h0001;
    end
    tick = advance && (state_reg.presc_cnt >= div_last);
    wrap_hit = tick && (state_reg.count_value == i_reload_value);
  end

  // Next state of the timer
  always_comb begin
    state_next = state_reg;
    state_next.pin_meta = i_external_count_pin;
    state_next.pin_sync = state_reg.pin_meta;
    state_next.filt_prev = filt_level;
    state_next.overflow = wrap_hit;
    // Prescaler
    if (advance) begin
      state_next.presc_cnt = tick ? bt_pkg::BT_PRESCALE_RESET
                                  : state_reg.presc_cnt + 16'h0001;
    end
    // Counter, a reload below the count restarts from zero without overflow
    if (i_count_wr) begin
      state_next.count_value = i_count_wdata;
    end else if (tick) begin
      if (state_reg.count_value >= i_reload_value) begin
        state_next.count_value = bt_pkg::BT_COUNT_RESET;
      end else begin
        state_next.count_value = state_reg.count_value + 16'h0001;
      end
    end
    // Enable: software write, then hardware trigger set, then single-run clear
    if (i_enable_wr) begin
      state_next.enable = i_enable_wdata;
    end
    if (trigger_event) begin
      state_next.enable = 1'b1;
    end
    if (wrap_hit && i_single_run_select) begin
      state_next.enable = 1'b0;
    end
    // Flags: a set in the same cycle beats the clear
    if (i_flag_clear_wr && !i_flag_clear_wdata[bt_pkg::BT_FLAG_WRAP_BIT]) begin
      state_next.wrap_flag = 1'b0;
    end
    if (i_flag_clear_wr && !i_flag_clear_wdata[bt_pkg::BT_FLAG_TRIG_BIT]) begin
      state_next.trigger_flag = 1'b0;
    end
    if (wrap_hit) begin
      state_next.wrap_flag = 1'b1;
    end
    if (trigger_event) begin
      state_next.trigger_flag = 1'b1;
    end
    // New prescale takes effect on overflow or on enable rising
    if (wrap_hit || (!state_reg.enable && state_next.enable)) begin
      state_next.presc_active = i_prescale_value;
      state_next.presc_cnt = bt_pkg::BT_PRESCALE_RESET;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign o_enable = state_reg.enable;
  assign o_count_value = state_reg.count_value;
  assign o_wrap_flag = state_reg.wrap_flag;
  assign o_trigger_flag = state_reg.trigger_flag;
  assign o_overflow = state_reg.overflow;
  assign o_irq = (state_reg.wrap_flag && i_irq_enable_wrap) ||
                 (state_reg.trigger_flag && i_irq_enable_trigger);

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence seq_quiet;
    !i_count_wr && !i_enable_wr && !trigger_event;
  endsequence

  sequence seq_timer_run;
    mode == bt_pkg::BT_MODE_TIMER && state_reg.enable &&
      state_reg.presc_active == 16'h0000 && state_reg.count_value < i_reload_value;
  endsequence

  // Gated mode running undivided with the gate open and room below reload
  sequence seq_gate_run;
    mode == bt_pkg::BT_MODE_GATED && state_reg.enable && gate_active &&
      state_reg.presc_active == 16'h0000 && state_reg.count_value < i_reload_value;
  endsequence

  // Counter mode seeing a pin edge with no division and room below reload
  sequence seq_pin_run;
    mode == bt_pkg::BT_MODE_COUNTER && !i_source_select && state_reg.enable && pin_edge &&
      state_reg.presc_active == 16'h0000 && state_reg.count_value < i_reload_value;
  endsequence

  AST_WRAP_SET: assert property (wrap_hit |=> o_overflow && o_wrap_flag)
    else $error("wrap flag or overflow pulse missing after reload match");

  AST_IRQ_WRAP: assert property ($rose(o_wrap_flag) && i_irq_enable_wrap |-> o_irq)
    else $error("interrupt not raised for enabled wrap flag");

  AST_FLAG_CLEAR: assert property (i_flag_clear_wr && !i_flag_clear_wdata[0] &&
      !wrap_hit |=> !o_wrap_flag)
    else $error("wrap flag not cleared by zero write");

  AST_TIMER_STEP: assert property (seq_timer_run ##0 seq_quiet |=>
      o_count_value == $past(o_count_value) + 16'h0001)
    else $error("timer mode did not step by one");

  AST_HOLD_DISABLED: assert property (!state_reg.enable && !i_count_wr |=>
      $stable(o_count_value))
    else $error("counter moved while disabled");

  AST_GATE_HOLD: assert property (mode == bt_pkg::BT_MODE_GATED && !gate_active &&
      !i_count_wr |=> $stable(o_count_value))
    else $error("counter moved with gate inactive");

  AST_TRIGGER: assert property (trigger_event && !wrap_hit |=>
      o_enable && o_trigger_flag)
    else $error("trigger did not set enable and trigger flag");

  AST_SINGLE_RUN: assert property (wrap_hit && i_single_run_select |=>
      !o_enable ##1 !o_overflow)
    else $error("single run did not stop after overflow");

  AST_WRAP_ZERO: assert property (wrap_hit && !i_count_wr |=>
      o_count_value == 16'h0000)
    else $error("counter did not wrap to zero");

  AST_SYNC_DELAY: assert property ((i_input_filter_setting == 3'h0 &&
      $stable(i_external_count_pin)) [*4] |-> filt_level == i_external_count_pin)
    else $error("pin level not seen after synchroniser delay");

  AST_GATE_STEP: assert property (seq_gate_run ##0 seq_quiet |=>
      o_count_value == $past(o_count_value) + 16'h0001)
    else $error("gated mode did not step with gate open");

  AST_PIN_STEP: assert property (seq_pin_run ##0 seq_quiet |=>
      o_count_value == $past(o_count_value) + 16'h0001)
    else $error("pin edge not counted");

  AST_COUNTER_HOLD: assert property (mode == bt_pkg::BT_MODE_COUNTER &&
      !cascade_pulse && !pin_edge && !i_count_wr |=> $stable(o_count_value))
    else $error("counter mode moved without an event");

  AST_TRIG_START: assert property (mode == bt_pkg::BT_MODE_TRIGGER &&
      i_enable_wr && i_enable_wdata && !wrap_hit |=> o_enable)
    else $error("enable write did not start trigger mode");

  AST_ENABLE_STOP: assert property (i_enable_wr && !i_enable_wdata &&
      !trigger_event |=> !o_enable)
    else $error("enable clear did not stop the timer");

endmodule

// ===== sim/bt_partner.sv
`timescale 1ns/10ps
// Far side of the timer: upstream cascaded timers and the shared count pin
module bt_partner #(
  parameter logic [2:0] SELF_CODE = 3'h0
) (
  // Bench requests
  input wire logic i_fire,
  input wire logic [2:0] i_code,
  input wire logic i_pin_level,
  // Towards the timer
  output logic [7:0] o_sources,
  output logic o_pin
);
  // One-cycle overflow pulse of the chosen upstream timer, never our own
  always_comb begin
    o_sources = 8'h00;
    if (i_fire && (i_code != SELF_CODE)) begin
      o_sources[i_code] = 1'b1;
    end
  end
  // One pin level shared by every basic timer
  assign o_pin = i_pin_level;
endmodule

// ===== sim/tb_basic_timer_operating_modes.sv
`timescale 1ns/10ps
module tb_basic_timer_operating_modes;
  localparam logic [2:0] SELF = 3'h5;
  logic i_clock, i_rst, sr, ss, sense, en_wr, en_wd, cnt_wr, fc_wr, irq_w, irq_t, fire, pin;
  logic [1:0] mode, fc_wd;
  logic [2:0] filt, csel;
  logic [15:0] prescale_value, rld, cnt_wd, held;
  logic [7:0] srcs;
  logic ext_pin, o_enable, o_wrap_flag, o_trigger_flag, o_overflow, o_irq;
  logic [15:0] o_count_value;
  int err_count, checks, seed, t, k;

  // Timer under test and its far side
  bt_basic_timer #(.SELF_CODE(SELF)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_mode(mode), .i_single_run_select(sr), .i_source_select(ss),
    .i_active_sense(sense), .i_input_filter_setting(filt), .i_prescale_value(prescale_value),
    .i_reload_value(rld), .i_cascade_source_select(csel), .i_enable_wr(en_wr),
    .i_enable_wdata(en_wd), .i_count_wr(cnt_wr), .i_count_wdata(cnt_wd),
    .i_flag_clear_wr(fc_wr), .i_flag_clear_wdata(fc_wd), .i_irq_enable_wrap(irq_w),
    .i_irq_enable_trigger(irq_t), .i_cascade_sources(srcs),
    .i_external_count_pin(ext_pin), .o_enable(o_enable), .o_count_value(o_count_value),
    .o_wrap_flag(o_wrap_flag), .o_trigger_flag(o_trigger_flag),
    .o_overflow(o_overflow), .o_irq(o_irq));
  bt_partner #(.SELF_CODE(SELF)) i_far (.i_fire(fire), .i_code(csel),
    .i_pin_level(pin), .o_sources(srcs), .o_pin(ext_pin));

  // Free-running bus clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // Expected cycles between overflows on the bus clock
  function automatic int period(input int p, input int r);
    return (p + 1) * (r + 1);
  endfunction

  // Expected count after a number of events on an event source
  function automatic int ev_count(input int p, input int n);
    return n / ((p == 0) ? 1 : p);
  endfunction

  // Steps past a number of edges, then settles off the edge
  task automatic step(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask

  // Compares a seen value with the expected one
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset held for two cycles
  task automatic do_reset();
    i_rst = 1'b1;
    step(2);
    i_rst = 1'b0;
    check({11'h000, o_enable, o_wrap_flag, o_trigger_flag, o_overflow, o_irq}, 16'h0000);
    check(o_count_value, 16'h0000);
  endtask

  // Software write of the enable bit
  task automatic write_en(input logic v);
    en_wr = 1'b1;
    en_wd = v;
    step(1);
    en_wr = 1'b0;
  endtask

  // Software write of the flag-clear word
  task automatic clear_flags(input logic [1:0] v);
    fc_wr = 1'b1;
    fc_wd = v;
    step(1);
    fc_wr = 1'b0;
    step(1);
  endtask

  // One upstream overflow pulse followed by a gap
  task automatic fire_pulse();
    fire = 1'b1;
    step(1);
    fire = 1'b0;
    step(1);
  endtask

  // Waits for an overflow pulse under a bounded count
  task automatic wait_ovf();
    t = 0;
    while (o_overflow !== 1'b1 && t < 2000) begin
      step(1);
      t++;
    end
    check(16'(t < 2000), 16'h1);
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #(20 * 40000);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {sr, ss, sense, en_wr, en_wd, cnt_wr, fc_wr, irq_w, irq_t, fire, pin} = 11'h000;
    {mode, fc_wd, filt, csel} = 10'h000;
    {prescale_value, rld, cnt_wd} = 48'h0;
    err_count = 0;
    checks = 0;
    seed = 32'hc8a8;
    do_reset();
    // Timer mode period, flags, interrupt, clear and single run
    for (k = 0; k < 4; k++) begin
      do_reset();
      mode = 2'h0;
      sr = 1'b0;
      irq_w = 1'b1;
      prescale_value = 16'($random(seed) & 3);
      rld = 16'(($random(seed) & 3) + 1);
      write_en(1'b1);
      wait_ovf();
      step(1);
      wait_ovf();
      check(16'(t + 1), 16'(period(prescale_value, rld)));
      check(16'(o_wrap_flag), 16'h1);
      check(16'(o_irq), 16'h1);
      write_en(1'b0);
      step(2);
      clear_flags(2'h3);
      check(16'(o_wrap_flag), 16'h1);
      clear_flags(2'h2);
      check(16'(o_wrap_flag), 16'h0);
      check(16'(o_irq), 16'h0);
      sr = 1'b1;
      cnt_wr = 1'b1;
      step(1);
      cnt_wr = 1'b0;
      check(o_count_value, 16'h0000);
      write_en(1'b1);
      wait_ovf();
      check(16'(o_enable), 16'h0);
      held = o_count_value;
      step(5);
      check(o_count_value, held);
    end
    // Counter mode on cascade pulses with prescale 0, 1 and 2
    for (k = 0; k < 3; k++) begin
      do_reset();
      mode = 2'h1;
      ss = 1'b1;
      sr = 1'b0;
      csel = 3'($random(seed) & 7);
      csel = (csel == SELF) ? 3'h0 : csel;
      prescale_value = 16'(k);
      rld = 16'h00ff;
      write_en(1'b1);
      repeat (6) fire_pulse();
      step(3);
      check(o_count_value, 16'(ev_count(k, 6)));
    end
    // Trigger-start mode: cascade trigger, halt and resume
    do_reset();
    mode = 2'h2;
    prescale_value = 16'h0000;
    irq_t = 1'b1;
    fire_pulse();
    step(1);
    check(16'(o_enable), 16'h1);
    check(16'(o_trigger_flag), 16'h1);
    check(16'(o_irq), 16'h1);
    held = o_count_value;
    step(4);
    check(o_count_value, held + 16'h0004);
    write_en(1'b0);
    held = o_count_value;
    step(4);
    check(o_count_value, held);
    fire_pulse();
    step(2);
    check(16'(o_count_value > held), 16'h1);
    // Trigger from the pin edge chosen by active sense
    sense = 1'($random(seed));
    pin = sense;
    ss = 1'b0;
    filt = 3'h0;
    do_reset();
    step(8);
    check(16'(o_enable), 16'h0);
    pin = ~sense;
    step(6);
    check(16'(o_enable), 16'h1);
    // Gated mode on the filtered pin
    filt = 3'($random(seed) & 7);
    do_reset();
    mode = 2'h3;
    pin = sense;
    step(12);
    write_en(1'b1);
    step(10);
    check(o_count_value, 16'h0000);
    pin = ~sense;
    step(20);
    pin = sense;
    step(15);
    check(o_count_value, 16'h0014);
    pin = ~sense;
    step(15);
    write_en(1'b0);
    held = o_count_value;
    step(5);
    check(o_count_value, held);
    // Counter mode on pin edges
    sense = ~sense;
    pin = sense;
    do_reset();
    mode = 2'h1;
    step(12);
    write_en(1'b1);
    repeat (5) begin
      pin = ~sense;
      step(8);
      pin = sense;
      step(8);
    end
    step(12);
    check(o_count_value, 16'h0005);
    wrap_up();
  end
endmodule
